/* bench/fpm_operator.sv */
`timescale 1ns/10ps
`default_nettype none
module fpm_operator (
   input wire logic clk,
   output logic [fpm_pkg::NKEY-1:0] keys
);
   initial keys = '0;
   // hold one key for n cycles, then leave the panel idle
   task automatic press(input int k, input int n);
      @(posedge clk);
      keys[k] <= 1'b1;
      repeat (n) @(posedge clk);
      keys[k] <= 1'b0;
      repeat (14) @(posedge clk);
   endtask : press
endmodule : fpm_operator
`default_nettype wire

/* bench/test_front_panel_mode_controller.sv */
`timescale 1ns/10ps
`default_nettype none
module test_front_panel_mode_controller;
   logic SYS_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, err;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, q;
   logic PREADY, PSLVERR, ZERO_STROBE, TARE_STROBE, SAVE_STROBE;
   logic [fpm_pkg::NKEY-1:0] KEYS;
   logic [1:0] CONTACTS = 2'h0, LED, led0;
   fpm_pkg::fpm_disp_t DISP;
   int n_fail = 0, n_compared = 0, nz = 0, nt = 0, ns = 0;
   logic [15:0] meas = 16'h1234;
   always #50 SYS_CLK = ~SYS_CLK;
   fpm_panel #(.HOLD_CYC(20), .DEB_CYC(2), .BLINK_CYC(4)) i_fpm_panel (
      .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .KEYS(KEYS), .CONTACTS(CONTACTS),
      .MEAS_VALUE(meas), .LIMIT_STATE(2'h1), .LED(LED), .DISP(DISP),
      .ZERO_STROBE(ZERO_STROBE), .TARE_STROBE(TARE_STROBE),
      .SAVE_STROBE(SAVE_STROBE));
   fpm_operator i_fpm_operator (.clk(SYS_CLK), .keys(KEYS));
   always @(posedge SYS_CLK) begin
      if (ZERO_STROBE === 1'b1) nz++;
      if (TARE_STROBE === 1'b1) nt++;
      if (SAVE_STROBE === 1'b1) ns++;
   end
   // ****************************************
   // bus and compare helpers
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge SYS_CLK);
      end while (PREADY !== 1'b1);
      q = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic chk_st(input logic [2:0] e);
      apb(1'b0, fpm_pkg::A_STAT, 32'h0);
      chk("state", {29'h0, e}, {29'h0, q[2:0]});
   endtask : chk_st
   task automatic key(input int k, input int n);
      i_fpm_operator.press(k, n);
   endtask : key
   task automatic give_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      apb(1'b0, fpm_pkg::A_LOCK, 32'h0);
      chk("lock", 32'h0, q);
      apb(1'b0, fpm_pkg::A_PASS, 32'h0);
      chk("password", 32'h0, q);
      chk_st(3'h0);
      apb(1'b0, fpm_pkg::A_LAST + 8'h04, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("led measure", 32'h1, {30'h0, LED});
      $display("test reset done");
   endtask : t_reset
   task automatic t_lock();
      key(fpm_pkg::K_ZERO, 8);
      key(fpm_pkg::K_TARE, 8);
      key(fpm_pkg::K_LIM, 8);
      chk("locked", 32'h0, nz + nt);
      chk_st(3'h0);
      CONTACTS <= 2'h1;
      repeat (8) @(posedge SYS_CLK);
      CONTACTS <= 2'h0;
      repeat (14) @(posedge SYS_CLK);
      chk("contact zero", 32'h1, nz);
      apb(1'b1, fpm_pkg::A_LOCK, 32'h7);
      meas <= 16'h4321;
      key(fpm_pkg::K_ZERO, 8);
      chk("zero", 32'h2, nz);
      apb(1'b0, fpm_pkg::A_PARAM + 8'h04, 32'h0);
      chk("zero value", 32'h4321, q);
      meas <= 16'h5678;
      key(fpm_pkg::K_TARE, 8);
      chk("tare", 32'h1, nt);
      apb(1'b0, fpm_pkg::A_TARE, 32'h0);
      chk("tare value", 32'h5678, q);
      key(fpm_pkg::K_LIM, 8);
      chk_st(3'h4);
      key(fpm_pkg::K_DIG, 8);
      key(fpm_pkg::K_MEAS, 8);
      key(fpm_pkg::K_CONF, 8);
      key(fpm_pkg::K_SET, 8);
      chk_st(3'h0);
      apb(1'b0, fpm_pkg::A_PARAM + 8'h0c, 32'h0);
      chk("level one", 32'h5678, q);
      $display("test lock done");
   endtask : t_lock
   task automatic t_open();
      key(fpm_pkg::K_SET, 30);
      chk_st(3'h3);
      chk("msg", {29'h0, fpm_pkg::MSG_GROUP}, {29'h0, DISP.msg});
      chk("group", 32'h0, {29'h0, DISP.group});
      led0 = LED;
      repeat (4) @(posedge SYS_CLK);
      chk("led", {30'h0, ~led0}, {30'h0, LED});
      key(fpm_pkg::K_SET, 30);
      chk_st(3'h0);
      $display("test open done");
   endtask : t_open
   task automatic t_pass();
      apb(1'b1, fpm_pkg::A_PASS, 32'h1);
      key(fpm_pkg::K_SET, 30);
      chk_st(3'h1);
      chk("msg", {29'h0, fpm_pkg::MSG_CODE}, {29'h0, DISP.msg});
      key(fpm_pkg::K_CONF, 8);
      chk_st(3'h0);
      key(fpm_pkg::K_SET, 30);
      repeat (4) key(fpm_pkg::K_DIG, 8);
      key(fpm_pkg::K_UP, 8);
      key(fpm_pkg::K_CONF, 8);
      chk_st(3'h3);
      chk("group", 32'h0, {29'h0, DISP.group});
      $display("test password done");
   endtask : t_pass
   task automatic t_save(input logic save, input logic [31:0] language_param);
      key(fpm_pkg::K_DIG, 8);
      chk_st(3'h2);
      key(fpm_pkg::K_UP, 8);
      key(fpm_pkg::K_MEAS, 8);
      chk("flash", 32'h1, {31'h0, DISP.flash});
      key(fpm_pkg::K_CONF, 8);
      apb(1'b0, fpm_pkg::A_PARAM, 32'h0);
      chk("language", language_param, q);
      key(fpm_pkg::K_SET, 30);
      chk_st(3'h6);
      key(save ? fpm_pkg::K_CONF : fpm_pkg::K_SET, 8);
      if (save) begin
         chk_st(3'h7);
         key(fpm_pkg::K_CONF, 8);
      end
      chk_st(3'h0);
      chk("saves", 32'h1, ns);
      $display("test save done");
   endtask : t_save
   initial begin
      repeat (6) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      t_reset();
      t_lock();
      t_open();
      t_pass();
      t_save(1'b1, 32'h1);
      apb(1'b1, fpm_pkg::A_PASS, 32'h0);
      key(fpm_pkg::K_SET, 30);
      t_save(1'b0, 32'h2);
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      n_fail++;
      give_verdict();
   end
endmodule : test_front_panel_mode_controller
`default_nettype wire

/* rtl/fpm_debounce.sv */
`timescale 1ns/10ps
`default_nettype none
module fpm_debounce #(
   parameter int W = 1,
   parameter int DEB_CYC = 4
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [W-1:0] RAW,
   output logic [W-1:0] LVL
);
   localparam int CW = $clog2(DEB_CYC + 1);

   generate
      if (DEB_CYC < 1) begin : g_bad
         $error("debounce count must be at least one");
      end
      for (genvar i = 0; i < W; i++) begin : g_bit
         logic [2:0] sy;
         logic [CW-1:0] cnt;
         always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               sy <= 3'h0;
            end else begin
               sy <= {sy[1:0], RAW[i]};
            end
         end
         // a change counts once stages two and three agree
         always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               cnt <= '0;
               LVL[i] <= 1'b0;
            end else if (sy[1] != sy[2] || sy[2] == LVL[i]) begin
               cnt <= '0;
            end else if (cnt == CW'(DEB_CYC - 1)) begin
               cnt <= '0;
               LVL[i] <= sy[2];
            end else begin
               cnt <= cnt + CW'(1);
            end
         end
      end
   endgenerate
endmodule : fpm_debounce
`default_nettype wire

/* rtl/fpm_panel.sv */
`timescale 1ns/10ps
`default_nettype none
module fpm_panel #(
   parameter int HOLD_CYC = fpm_pkg::HOLD_CYC,
   parameter int DEB_CYC = fpm_pkg::DEB_CYC,
   parameter int BLINK_CYC = fpm_pkg::BLINK_CYC
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [fpm_pkg::NKEY-1:0] KEYS,
   input wire logic [1:0] CONTACTS,
   input wire logic [15:0] MEAS_VALUE,
   input wire logic [1:0] LIMIT_STATE,
   output logic [1:0] LED,
   output fpm_pkg::fpm_disp_t DISP,
   output logic ZERO_STROBE,
   output logic TARE_STROBE,
   output logic SAVE_STROBE
);
   generate
      if (HOLD_CYC < 2 || BLINK_CYC < 1) begin : g_bad
         $error("hold and blink counts too small");
      end
   endgenerate

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] bcd_step(input logic [15:0] v,
      input logic [2:0] ptr, input logic up);
      logic [3:0] d;
      logic [3:0] sh;
      d = 4'h0;
      sh = 4'(12 - 4 * (ptr - 3'h1));
      d = 4'(v >> sh);
      if (up) begin
         d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
      end else begin
         d = (d == 4'h0) ? 4'h9 : d - 4'h1;
      end
      bcd_step = (v & ~(16'h000f << sh)) | (16'(d) << sh);
   endfunction : bcd_step

   function automatic logic takes_meas(input logic [2:0] p);
      takes_meas = (p == fpm_pkg::P_ZERO || p == fpm_pkg::P_RANGE ||
         p == fpm_pkg::P_LVL1 || p == fpm_pkg::P_LVL2);
   endfunction : takes_meas

   // ****************************************
   // key conditioning
   // ****************************************
   logic [fpm_pkg::NRAW-1:0] lvl;
   logic [fpm_pkg::NRAW-1:0] lvl_prev;
   logic [fpm_pkg::NRAW-1:0] rise;
   logic [31:0] hold_cnt;
   logic set_long;
   logic set_short;

   fpm_debounce #(
      .W(fpm_pkg::NRAW),
      .DEB_CYC(DEB_CYC)
   ) u_deb (
      .SYS_CLK(SYS_CLK),
      .SYS_RST(SYS_RST),
      .RAW({CONTACTS, KEYS}),
      .LVL(lvl)
   );

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lvl_prev <= '0;
      end else begin
         lvl_prev <= lvl;
      end
   end
   assign rise = lvl & ~lvl_prev;

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         hold_cnt <= 32'h0;
      end else if (!lvl[fpm_pkg::K_SET]) begin
         hold_cnt <= 32'h0;
      end else if (hold_cnt != 32'(HOLD_CYC)) begin
         hold_cnt <= hold_cnt + 32'h1;
      end
   end
   assign set_long = lvl[fpm_pkg::K_SET] && hold_cnt == 32'(HOLD_CYC - 1);
   assign set_short = !lvl[fpm_pkg::K_SET] && lvl_prev[fpm_pkg::K_SET] &&
      hold_cnt < 32'(HOLD_CYC - 1);

   // ****************************************
   // mode state machine
   // ****************************************
   localparam fpm_pkg::fpm_state_t ST_MEAS = fpm_pkg::ST_MEAS;
   localparam fpm_pkg::fpm_state_t ST_CODE = fpm_pkg::ST_CODE;
   localparam fpm_pkg::fpm_state_t ST_PROG = fpm_pkg::ST_PROG;
   localparam fpm_pkg::fpm_state_t ST_EDIT = fpm_pkg::ST_EDIT;
   localparam fpm_pkg::fpm_state_t ST_STORE = fpm_pkg::ST_STORE;
   localparam fpm_pkg::fpm_state_t ST_DONE = fpm_pkg::ST_DONE;
   localparam fpm_pkg::fpm_state_t ST_LIMIT = fpm_pkg::ST_LIMIT;
   fpm_pkg::fpm_state_t state;
   logic [2:0] lock;
   logic [15:0] password;
   logic [15:0] tare;
   logic [15:0] param_val [fpm_pkg::NPARAM];
   logic [15:0] entry;
   logic [2:0] ptr;
   logic [2:0] pidx;
   logic [2:0] group;
   logic lim_mode;
   logic dirty;
   logic k_conf;
   logic pw_zero;
   logic pw_ok;
   logic edit_done;
   logic in_prog;

   assign k_conf = rise[fpm_pkg::K_CONF];
   assign pw_zero = password == 16'h0000;
   assign pw_ok = entry == password;
   assign edit_done = state == ST_EDIT && k_conf;
   assign in_prog = !lim_mode && (state == ST_PROG || state == ST_EDIT ||
      state == ST_STORE || state == ST_DONE);

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= ST_MEAS;
      end else begin
         unique case (state)
            ST_MEAS: begin
               if (set_long) begin
                  state <= pw_zero ? ST_PROG : ST_CODE;
               end else if (rise[fpm_pkg::K_LIM] &&
                  lock[fpm_pkg::LK_LIMIT]) begin
                  state <= ST_LIMIT;
               end
            end
            ST_CODE: begin
               if (k_conf) begin
                  state <= pw_ok ? ST_PROG : ST_MEAS;
               end
            end
            ST_PROG: begin
               if (set_long) begin
                  state <= dirty ? ST_STORE : ST_MEAS;
               end else if (rise[fpm_pkg::K_DIG]) begin
                  state <= ST_EDIT;
               end
            end
            ST_LIMIT: begin
               if (set_short || set_long) begin
                  state <= ST_MEAS;
               end else if (rise[fpm_pkg::K_DIG]) begin
                  state <= ST_EDIT;
               end
            end
            ST_EDIT: begin
               if (k_conf) begin
                  state <= lim_mode ? ST_LIMIT : ST_PROG;
               end
            end
            ST_STORE: begin
               if (k_conf) begin
                  state <= ST_DONE;
               end else if (set_short) begin
                  state <= ST_MEAS;
               end
            end
            ST_DONE: begin
               if (k_conf) begin
                  state <= ST_MEAS;
               end
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lim_mode <= 1'b0;
      end else if (state == ST_MEAS) begin
         lim_mode <= rise[fpm_pkg::K_LIM];
      end
   end

   // group and parameter browsing; limit mode sees both levels only
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         group <= fpm_pkg::G_DIALOG;
         pidx <= fpm_pkg::P_LANGUAGE_PARAM;
      end else if (state == ST_MEAS) begin
         group <= fpm_pkg::G_DIALOG;
         pidx <= rise[fpm_pkg::K_LIM] ? fpm_pkg::P_LVL1 : fpm_pkg::P_LANGUAGE_PARAM;
      end else if (state == ST_PROG) begin
         if (set_short) begin
            group <= (group == fpm_pkg::G_LAST) ? 3'h0 : group + 3'h1;
         end
         if (rise[fpm_pkg::K_PAR]) begin
            pidx <= (pidx == fpm_pkg::P_LAST) ? 3'h0 : pidx + 3'h1;
         end
      end else if (state == ST_LIMIT && rise[fpm_pkg::K_PAR]) begin
         pidx <= (pidx == fpm_pkg::P_LVL1) ? fpm_pkg::P_LVL2 :
            fpm_pkg::P_LVL1;
      end
   end

   // ****************************************
   // value entry
   // ****************************************
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         entry <= 16'h0000;
         ptr <= 3'h0;
      end else if (state == ST_MEAS) begin
         entry <= 16'h0000;
         ptr <= 3'h0;
      end else if ((state == ST_PROG || state == ST_LIMIT) &&
         rise[fpm_pkg::K_DIG]) begin
         entry <= param_val[pidx];
         ptr <= 3'h0;
      end else if (state == ST_CODE || state == ST_EDIT) begin
         if (rise[fpm_pkg::K_DIG]) begin
            ptr <= (ptr == fpm_pkg::PTR_LAST) ? 3'h1 : ptr + 3'h1;
         end else if (state == ST_EDIT && rise[fpm_pkg::K_MEAS] &&
            takes_meas(pidx)) begin
            entry <= MEAS_VALUE;
         end else if (rise[fpm_pkg::K_UP] || rise[fpm_pkg::K_DN]) begin
            if (state == ST_EDIT && pidx == fpm_pkg::P_LANGUAGE_PARAM) begin
               if (rise[fpm_pkg::K_UP]) begin
                  entry <= (entry >= fpm_pkg::LANGUAGE_PARAM_LAST) ? 16'h0 :
                     entry + 16'h1;
               end else begin
                  entry <= (entry == 16'h0) ? fpm_pkg::LANGUAGE_PARAM_LAST :
                     entry - 16'h1;
               end
            end else if (ptr != 3'h0) begin
               entry <= bcd_step(entry, ptr, rise[fpm_pkg::K_UP]);
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dirty <= 1'b0;
      end else if (state == ST_MEAS) begin
         dirty <= 1'b0;
      end else if (edit_done && !lim_mode && entry != param_val[pidx]) begin
         dirty <= 1'b1;
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   logic wr_en;
   logic [7:0] pofs;
   logic [2:0] pw_idx;
   logic a_ok;

   assign wr_en = PSEL && PENABLE && PWRITE;
   assign pofs = PADDR - fpm_pkg::A_PARAM;
   assign pw_idx = pofs[4:2];
   assign a_ok = PADDR[1:0] == 2'h0 && PADDR <= fpm_pkg::A_LAST;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !a_ok;

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lock <= fpm_pkg::LOCK_RST;
         password <= fpm_pkg::PASS_RST;
      end else if (wr_en && PADDR == fpm_pkg::A_LOCK) begin
         lock <= PWDATA[2:0];
      end else if (wr_en && PADDR == fpm_pkg::A_PASS) begin
         password <= PWDATA[15:0];
      end
   end

   // panel confirm and zero capture share the store with the bus
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int i = 0; i < fpm_pkg::NPARAM; i++) begin
            param_val[i] <= fpm_pkg::PARAM_RST;
         end
      end else if (edit_done) begin
         param_val[pidx] <= entry;
      end else if (ZERO_STROBE) begin
         param_val[fpm_pkg::P_ZERO] <= MEAS_VALUE;
      end else if (wr_en && a_ok && PADDR >= fpm_pkg::A_PARAM) begin
         param_val[pw_idx] <= PWDATA[15:0];
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tare <= 16'h0000;
      end else if (TARE_STROBE) begin
         tare <= MEAS_VALUE;
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PRDATA <= 32'h0;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         if (!a_ok) begin
            PRDATA <= 32'h0;
         end else if (PADDR == fpm_pkg::A_LOCK) begin
            PRDATA <= {29'h0, lock};
         end else if (PADDR == fpm_pkg::A_PASS) begin
            PRDATA <= {16'h0, password};
         end else if (PADDR == fpm_pkg::A_STAT) begin
            PRDATA <= {27'h0, lim_mode, dirty, state};
         end else if (PADDR == fpm_pkg::A_TARE) begin
            PRDATA <= {16'h0, tare};
         end else begin
            PRDATA <= {16'h0, param_val[pw_idx]};
         end
      end
   end

   // ****************************************
   // strobes to the measurement core
   // ****************************************
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ZERO_STROBE <= 1'b0;
         TARE_STROBE <= 1'b0;
         SAVE_STROBE <= 1'b0;
      end else begin
         ZERO_STROBE <= state == ST_MEAS && (rise[fpm_pkg::C_ZERO] ||
            (rise[fpm_pkg::K_ZERO] && lock[fpm_pkg::LK_ZERO]));
         TARE_STROBE <= state == ST_MEAS && (rise[fpm_pkg::C_TARE] ||
            (rise[fpm_pkg::K_TARE] && lock[fpm_pkg::LK_TARE]));
         SAVE_STROBE <= state == ST_DONE && k_conf;
      end
   end

   // ****************************************
   // blink, indicators and display
   // ****************************************
   logic [31:0] blink_cnt;
   logic phase;
   fpm_pkg::fpm_disp_t next_disp;

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         blink_cnt <= 32'h0;
         phase <= 1'b0;
      end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
         blink_cnt <= 32'h0;
         phase <= !phase;
      end else begin
         blink_cnt <= blink_cnt + 32'h1;
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         LED <= 2'h0;
      end else begin
         LED <= in_prog ? {!phase, phase} : LIMIT_STATE;
      end
   end

   always_comb begin
      next_disp = '0;
      next_disp.group = group;
      next_disp.param = pidx;
      next_disp.value = entry;
      if (ptr != 3'h0 && !phase) begin
         next_disp.blank = 4'h8 >> (ptr - 3'h1);
      end
      unique case (state)
         ST_MEAS: begin
            next_disp.msg = fpm_pkg::MSG_VALUE;
            next_disp.value = MEAS_VALUE;
         end
         ST_CODE: begin
            next_disp.msg = (ptr == 3'h0) ? fpm_pkg::MSG_CODE :
               fpm_pkg::MSG_VALUE;
         end
         ST_PROG, ST_LIMIT: begin
            next_disp.msg = fpm_pkg::MSG_GROUP;
         end
         ST_EDIT: begin
            next_disp.msg = fpm_pkg::MSG_VALUE;
            next_disp.flash = pidx == fpm_pkg::P_LANGUAGE_PARAM &&
               entry != param_val[pidx];
         end
         ST_STORE: begin
            next_disp.msg = fpm_pkg::MSG_STORE;
         end
         ST_DONE: begin
            next_disp.msg = fpm_pkg::MSG_DONE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         DISP <= '0;
      end else begin
         DISP <= next_disp;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);

   sequence s_store_ok;
      state == ST_STORE && k_conf;
   endsequence
   sequence s_done_ok;
      state == ST_DONE && k_conf;
   endsequence

   a_zero_key: assert property (
      state == ST_MEAS && rise[fpm_pkg::K_ZERO] && lock[fpm_pkg::LK_ZERO]
      |=> ZERO_STROBE ##1 param_val[fpm_pkg::P_ZERO] == $past(MEAS_VALUE))
      else $error("zero not captured");
   a_tare_lock: assert property (
      rise[fpm_pkg::K_TARE] && !lock[fpm_pkg::LK_TARE] &&
      !rise[fpm_pkg::C_TARE] |=> !TARE_STROBE)
      else $error("locked tare key acted");
   a_limit_lock: assert property (
      state == ST_MEAS && rise[fpm_pkg::K_LIM] && !lock[fpm_pkg::LK_LIMIT]
      && !set_long |=> state == ST_MEAS)
      else $error("locked limit key acted");
   a_pw_direct: assert property (
      state == ST_MEAS && set_long && pw_zero
      |=> state == ST_PROG && group == fpm_pkg::G_DIALOG)
      else $error("no direct entry");
   a_pw_prompt: assert property (
      state == ST_MEAS && set_long && !pw_zero
      |=> state == ST_CODE ##2 DISP.msg == fpm_pkg::MSG_CODE || ptr != 0)
      else $error("no password prompt");
   a_pw_wrong: assert property (
      state == ST_CODE && k_conf && !pw_ok |=> state == ST_MEAS)
      else $error("wrong password accepted");
   a_pw_right: assert property (
      state == ST_CODE && k_conf && pw_ok
      |=> state == ST_PROG && group == fpm_pkg::G_DIALOG)
      else $error("right password refused");
   a_leds_alt: assert property (
      in_prog |=> LED[0] != LED[1])
      else $error("indicators not alternating");
   a_store_seq: assert property (
      s_store_ok |=> state == ST_DONE)
      else $error("store sequence broken");
   a_done_seq: assert property (
      s_done_ok |=> state == ST_MEAS && SAVE_STROBE)
      else $error("done sequence broken");
   a_discard: assert property (
      state == ST_STORE && set_short && !k_conf
      |=> state == ST_MEAS && !SAVE_STROBE)
      else $error("discard failed");
   a_meas_only: assert property (
      state == ST_EDIT && pidx == fpm_pkg::P_LANGUAGE_PARAM && rise[fpm_pkg::K_MEAS]
      |=> $stable(entry))
      else $error("input taken for table value");
   a_long_hold: assert property (
      set_long |-> lvl[fpm_pkg::K_SET] && $past(lvl[fpm_pkg::K_SET], 2))
      else $error("long press unheld");

endmodule : fpm_panel
`default_nettype wire

/* rtl/fpm_pkg.sv */
// Function
// - zero, tare and limit key functions can be locked
// - zero key or contact captures input as zero
// - tare key or contact stores measurement as tare
// - limit key edits only both levels, if unlocked
// - level set by digits or adopted input
// - indicators flash alternately in programming mode
// - set held two seconds requests programming
// - zero password enters programming at dialog group
// - nonzero password shows password prompt
// - digit key once, four digits, confirm
// - wrong password returns to measure mode
// - right password enters programming at dialog group
// - digit key steps flashing digit, up/down change it
// - changed table value flashes until confirmed
// - measured input only for zero, range, levels
// - long set after change: store, done, measure
// - set at store prompt discards, returns measure
// - settings persist only when written to set
// - password zero means unprotected, 1-9999 protects
package fpm_pkg;

   localparam int CLK_HZ = 10_000_000;
   localparam int HOLD_MS = 2000;
   localparam int DEB_MS = 10;
   localparam int BLINK_MS = 250;
   localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
   localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);
   localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);

   // ****************************************
   // key and contact positions
   // ****************************************
   localparam int NKEY = 10;
   localparam int NRAW = 12;
   localparam int K_SET = 0;
   localparam int K_PAR = 1;
   localparam int K_DIG = 2;
   localparam int K_UP = 3;
   localparam int K_DN = 4;
   localparam int K_MEAS = 5;
   localparam int K_CONF = 6;
   localparam int K_ZERO = 7;
   localparam int K_TARE = 8;
   localparam int K_LIM = 9;
   localparam int C_ZERO = 10;
   localparam int C_TARE = 11;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] A_LOCK = 8'h00;
   localparam logic [7:0] A_PASS = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_TARE = 8'h0c;
   localparam logic [7:0] A_PARAM = 8'h10;
   localparam logic [7:0] A_LAST = 8'h20;
   localparam int LK_ZERO = 0;
   localparam int LK_TARE = 1;
   localparam int LK_LIMIT = 2;
   localparam logic [2:0] LOCK_RST = 3'h0;
   localparam logic [15:0] PASS_RST = 16'h0000;
   localparam logic [15:0] PARAM_RST = 16'h0000;

   // ****************************************
   // parameters and groups
   // ****************************************
   localparam int NPARAM = 5;
   localparam logic [2:0] P_LANGUAGE_PARAM = 3'h0;
   localparam logic [2:0] P_ZERO = 3'h1;
   localparam logic [2:0] P_RANGE = 3'h2;
   localparam logic [2:0] P_LVL1 = 3'h3;
   localparam logic [2:0] P_LVL2 = 3'h4;
   localparam logic [2:0] P_LAST = 3'h4;
   localparam logic [2:0] G_DIALOG = 3'h0;
   localparam logic [2:0] G_LAST = 3'h6;
   localparam logic [15:0] LANGUAGE_PARAM_LAST = 16'h0002;
   localparam logic [2:0] PTR_LAST = 3'h4;

   typedef enum logic [2:0] {
      ST_MEAS = 3'h0,
      ST_CODE = 3'h1,
      ST_PROG = 3'h3,
      ST_EDIT = 3'h2,
      ST_STORE = 3'h6,
      ST_DONE = 3'h7,
      ST_LIMIT = 3'h4
   } fpm_state_t;

   typedef enum logic [2:0] {
      MSG_VALUE = 3'h0,
      MSG_CODE = 3'h1,
      MSG_GROUP = 3'h2,
      MSG_STORE = 3'h3,
      MSG_DONE = 3'h4
   } fpm_msg_t;

   typedef struct packed {
      fpm_msg_t msg;
      logic [2:0] group;
      logic [2:0] param;
      logic [15:0] value;
      logic [3:0] blank;
      logic flash;
   } fpm_disp_t;

endpackage : fpm_pkg
